// ### hdl/sleep_power_manager.sv
// Sleep mode sequencer and per-peripheral clock gating behind an AXI4-Lite slave.
// Assumes the CPU pulses haltOpcode, the interrupt controller supplies wake
// sources and does priority ordering, and clock enables feed clock gates.
//
// What this block does
// - Halt opcode enters the selected low-power mode and stops execution until wake.
// - Interrupt wake serves its routine then resumes after the halt opcode.
// - Higher-priority pending interrupts are served first, in priority order.
// - CPU stays stalled exactly four cycles after any wake before executing.
// - Idle stops CPU clock and memory; other clocks run; any interrupt wakes.
// - Power-down stops all clocks; wake on address match, async port, USB resume.
// - Power-save is power-down plus enabled counter; counter interrupt also wakes.
// - Standby is power-down with system clock sources kept running.
// - Extended standby is power-save with system clock sources kept running.
// - Wake from modes stopping the oscillator waits for its startup time.
// - Register file, SRAM and I/O registers are kept through every mode.
// - Reset during sleep restarts from the reset vector.
// - Set clock-gate bit stops that peripheral clock and blocks its register access.
// - Clearing a clock-gate bit resumes the peripheral in its frozen state.
// - Gate bits for absent peripherals have no effect.
// - Enabled ADC stays on in sleep; re-enable forces an extended conversion.
// - Comparator disabled in non-idle sleep; its reference stays unless comparator off.
// - Brownout detector stays enabled in sleep; may be sampled in deep modes.
// - Enabled watchdog keeps running in every low-power mode.
// - Pin input buffers disabled whenever the peripheral clock is stopped.
// - Three-bit mode field: 000,010,011,110,111 valid; others reserved.
// - Halt opcode sleeps only while the arm bit is set.
`timescale 1ns/1ps
`include "sleep_power_manager_cfg.svh"

module sleep_power_manager
  import sleep_power_manager_pkg::*;
#(
  parameter int GATE_W = 8,
  parameter logic [GATE_W-1:0] PRESENT_MASK = 8'hFF,
  parameter int OSC_STARTUP_NS = `SPM_OSC_STARTUP_NS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU side
  input wire logic haltOpcode,
  output logic cpuStall,
  output logic nvmStop,
  // Wake sources from pins or other domains
  input wire logic anyIrq,
  input wire logic twoWireAddrMatch,
  input wire logic asyncPortIrq,
  input wire logic usbResume,
  input wire logic rtcIrq,
  input wire logic rtcEnabled,
  // Fuse and watchdog levels
  input wire logic brownoutThresholdFuses,
  input wire logic watchdogEnabled,
  // Clock enables
  output logic cpuClkEn,
  output logic peripheralClkEn,
  output logic rtcClkEn,
  output logic sysOscEn,
  output logic rtcOscEn,
  output logic [GATE_W-1:0] periphClkEn,
  // Analog and pin control
  output logic inputBufEn,
  output logic adcEn,
  output logic adcExtendedConv,
  output logic cmpEn,
  output logic vrefEn,
  output logic brownoutEn,
  output logic brownoutSampled,
  output logic watchdogRun
);

  localparam int OSC_CYCLES_I = (OSC_STARTUP_NS + `SPM_CLK_PERIOD_NS - 1) / `SPM_CLK_PERIOD_NS;
  localparam logic [15:0] OSC_CYCLES = 16'(OSC_CYCLES_I < 1 ? 1 : OSC_CYCLES_I);

  // Register state
  logic [7:0] sleepControl_r;
  logic [GATE_W-1:0] clockGate_r;
  logic [7:0] analogCtrl_r;
  seq_state_t state_r;
  logic [2:0] activeMode_r;
  logic [15:0] oscCnt_r;
  logic [2:0] stallCnt_r;
  logic adcWasOff_r;

  // Three-stage synchronisers for the asynchronous wake sources
  logic [4:0] wakeS1_r, wakeS2_r, wakeS3_r, wakeLvl_r;
  logic [4:0] wakeRaw;
  logic [4:0] wakeSync;
  assign wakeRaw = {rtcIrq, usbResume, asyncPortIrq, twoWireAddrMatch, anyIrq};
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wakeS1_r <= 5'h00;
      wakeS2_r <= 5'h00;
      wakeS3_r <= 5'h00;
      wakeLvl_r <= 5'h00;
    end else begin
      wakeS1_r <= wakeRaw;
      wakeS2_r <= wakeS1_r;
      wakeS3_r <= wakeS2_r;
      // Level moves only while stages two and three agree
      wakeLvl_r <= (wakeS2_r & wakeS3_r) | (wakeLvl_r & (wakeS2_r | wakeS3_r));
    end
  end
  assign wakeSync = wakeLvl_r;

  // Mode decode, reserved codes fall back to idle
  logic [2:0] selMode;
  always_comb begin
    case (sleepControl_r[`SPM_MODE_MSB:`SPM_MODE_LSB])
      MODE_ALL_CLOCKS_OFF, MODE_COUNTER_KEPT, MODE_OSCILLATORS_KEPT,
      MODE_OSCILLATORS_AND_COUNTER_KEPT: selMode = sleepControl_r[`SPM_MODE_MSB:`SPM_MODE_LSB];
      default: selMode = MODE_IDLE;
    endcase
  end

  // Per-mode clock keeps
  logic keepPer, keepRtc, keepSysOsc, keepRtcOsc;
  always_comb begin
    keepPer = 1'b0;
    keepRtc = 1'b0;
    keepSysOsc = 1'b0;
    keepRtcOsc = 1'b0;
    case (activeMode_r)
      MODE_IDLE: begin
        keepPer = 1'b1;
        keepRtc = 1'b1;
        keepSysOsc = 1'b1;
        keepRtcOsc = 1'b1;
      end
      MODE_COUNTER_KEPT: begin
        keepRtc = rtcEnabled;
        keepRtcOsc = rtcEnabled;
      end
      MODE_OSCILLATORS_KEPT: begin
        keepSysOsc = 1'b1;
      end
      MODE_OSCILLATORS_AND_COUNTER_KEPT: begin
        keepRtc = rtcEnabled;
        keepRtcOsc = rtcEnabled;
        keepSysOsc = 1'b1;
      end
      default: begin // all clocks off
        keepPer = 1'b0;
      end
    endcase
  end

  // Wake qualification per mode
  logic wakeOk;
  always_comb begin
    wakeOk = wakeSync[1] | wakeSync[2] | wakeSync[3];
    if (activeMode_r == MODE_IDLE) begin
      wakeOk = wakeOk | wakeSync[0] | wakeSync[4];
    end else if (activeMode_r == MODE_COUNTER_KEPT
                 || activeMode_r == MODE_OSCILLATORS_AND_COUNTER_KEPT) begin
      wakeOk = wakeOk | (wakeSync[4] & rtcEnabled);
    end
  end

  // Sleep sequencer; reset from any state returns to run
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_RUN;
      activeMode_r <= 3'h0;
      oscCnt_r <= 16'h0000;
      stallCnt_r <= 3'h0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (haltOpcode && sleepControl_r[`SPM_ARM_BIT]) begin
            state_r <= ST_SLEEP;
            activeMode_r <= selMode;
          end
        end
        ST_SLEEP: begin
          if (wakeOk) begin
            if (!keepSysOsc) begin
              state_r <= ST_OSC_START;
              oscCnt_r <= OSC_CYCLES;
            end else begin
              state_r <= ST_STALL;
              stallCnt_r <= `SPM_WAKE_STALL_CYCLES;
            end
          end
        end
        ST_OSC_START: begin
          if (oscCnt_r == 16'h0001) begin
            state_r <= ST_STALL;
            stallCnt_r <= `SPM_WAKE_STALL_CYCLES;
          end
          oscCnt_r <= oscCnt_r - 16'h0001;
        end
        ST_STALL: begin
          // Then CPU takes pending irqs in priority order
          if (stallCnt_r == 3'h1) begin
            state_r <= ST_RUN;
            activeMode_r <= MODE_IDLE;
          end
          stallCnt_r <= stallCnt_r - 3'h1;
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Clock enables and sleep-dependent outputs, all registered
  logic sleeping;
  logic waking;
  logic perStopped;
  assign sleeping = (state_r == ST_SLEEP);
  // Domain clocks stay off until the oscillator has started
  assign waking = sleeping || (state_r == ST_OSC_START);
  assign perStopped = waking && !keepPer;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cpuClkEn <= 1'b1;
      cpuStall <= 1'b0;
      nvmStop <= 1'b0;
      peripheralClkEn <= 1'b1;
      rtcClkEn <= 1'b1;
      sysOscEn <= 1'b1;
      rtcOscEn <= 1'b1;
      inputBufEn <= 1'b1;
      cmpEn <= 1'b0;
      vrefEn <= 1'b0;
      brownoutSampled <= 1'b0;
    end else begin
      // Clock gating only stops clocks, state held
      cpuClkEn <= (state_r == ST_RUN) || (state_r == ST_STALL);
      cpuStall <= (state_r != ST_RUN);
      nvmStop <= sleeping || (state_r == ST_OSC_START);
      peripheralClkEn <= !perStopped;
      rtcClkEn <= !waking || keepRtc;
      sysOscEn <= !sleeping || keepSysOsc;
      rtcOscEn <= !sleeping || keepRtcOsc;
      inputBufEn <= !perStopped;
      cmpEn <= analogCtrl_r[`SPM_CMP_EN_BIT]
               && !(waking && activeMode_r != MODE_IDLE);
      vrefEn <= analogCtrl_r[`SPM_CMP_EN_BIT] && analogCtrl_r[`SPM_CMP_VREF_BIT];
      brownoutSampled <= analogCtrl_r[`SPM_BOD_SAMPLED_BIT]
                         && sleeping && activeMode_r != MODE_IDLE;
    end
  end

  // Levels kept in every mode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      adcEn <= 1'b0;
      adcExtendedConv <= 1'b0;
      adcWasOff_r <= 1'b1;
      brownoutEn <= 1'b0;
      watchdogRun <= 1'b0;
    end else begin
      adcEn <= analogCtrl_r[`SPM_ADC_EN_BIT];
      adcWasOff_r <= !analogCtrl_r[`SPM_ADC_EN_BIT];
      if (!analogCtrl_r[`SPM_ADC_EN_BIT]) begin
        adcExtendedConv <= 1'b1;
      end else if (!adcWasOff_r && adcEn) begin
        adcExtendedConv <= 1'b0;
      end
      brownoutEn <= brownoutThresholdFuses;
      watchdogRun <= watchdogEnabled;
    end
  end

  // Per-peripheral gates; absent ones stay clocked outside deep sleep, state frozen while gated
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      periphClkEn <= {GATE_W{1'b1}};
    end else begin
      periphClkEn <= ~(clockGate_r & PRESENT_MASK) & {GATE_W{!perStopped}};
    end
  end

  // AXI4-Lite write path: address and data in either order
  logic awHeld_r, wHeld_r;
  logic [3:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 4'h0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r == `SPM_OFS_SLEEP_CONTROL || awAddr_r == `SPM_OFS_CLOCK_GATE
                        || awAddr_r == `SPM_OFS_ANALOG_CTRL || awAddr_r == `SPM_OFS_STATUS)
                       ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes through byte lane 0
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sleepControl_r <= `SPM_SLEEP_CONTROL_RST;
      clockGate_r <= `SPM_CLOCK_GATE_RST;
      analogCtrl_r <= `SPM_ANALOG_CTRL_RST;
    end else if (doWrite && wStrb_r[0]) begin
      case (awAddr_r)
        `SPM_OFS_SLEEP_CONTROL: sleepControl_r <= {4'h0, wData_r[3:0]};
        `SPM_OFS_CLOCK_GATE: clockGate_r <= wData_r[GATE_W-1:0];
        `SPM_OFS_ANALOG_CTRL: analogCtrl_r <= {4'h0, wData_r[3:0]};
        default: analogCtrl_r <= analogCtrl_r;
      endcase
    end
  end

  // AXI4-Lite read path
  logic [31:0] rdMux;
  always_comb begin
    case (s_axi_araddr)
      `SPM_OFS_SLEEP_CONTROL: rdMux = {24'h000000, sleepControl_r};
      `SPM_OFS_CLOCK_GATE: rdMux = {{(32-GATE_W){1'b0}}, clockGate_r};
      `SPM_OFS_STATUS: rdMux = {23'h000000, activeMode_r, adcExtendedConv, state_r, cpuStall};
      `SPM_OFS_ANALOG_CTRL: rdMux = {24'h000000, analogCtrl_r};
      default: rdMux = 32'h00000000;
    endcase
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ### hdl/sleep_power_manager_cfg.svh
// Constants for the sleep and clock-gate manager: offsets, fields, resets, timing.
// Assumes inclusion by its bare name from the design file and the bench.
`ifndef SLEEP_POWER_MANAGER_CFG_SVH
`define SLEEP_POWER_MANAGER_CFG_SVH
// Register byte offsets on the AXI4-Lite bus
`define SPM_OFS_SLEEP_CONTROL 4'h0
`define SPM_OFS_CLOCK_GATE 4'h4
`define SPM_OFS_STATUS 4'h8
`define SPM_OFS_ANALOG_CTRL 4'hC
// Sleep control fields
`define SPM_ARM_BIT 0
`define SPM_MODE_LSB 1
`define SPM_MODE_MSB 3
`define SPM_SLEEP_CONTROL_RST 8'h00
`define SPM_CLOCK_GATE_RST 8'h00
`define SPM_ANALOG_CTRL_RST 8'h00
// Analog control fields
`define SPM_ADC_EN_BIT 0
`define SPM_CMP_EN_BIT 1
`define SPM_CMP_VREF_BIT 2
`define SPM_BOD_SAMPLED_BIT 3
// Wake stall: four CPU cycles
`define SPM_WAKE_STALL_CYCLES 3'h4
// Default oscillator startup time in ns
`define SPM_OSC_STARTUP_NS 1000
`define SPM_CLK_PERIOD_NS 10
`endif

// ### hdl/sleep_power_manager_pkg.sv
// Types shared by the sleep and clock-gate manager.
// Assumes the cfg header sits on the include path.
package sleep_power_manager_pkg;
  // Low-power mode encodings
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_ALL_CLOCKS_OFF = 3'h2,
    MODE_COUNTER_KEPT = 3'h3,
    MODE_OSCILLATORS_KEPT = 3'h6,
    MODE_OSCILLATORS_AND_COUNTER_KEPT = 3'h7
  } low_power_mode_t;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_OSC_START = 4'h4,
    ST_STALL = 4'h8
  } seq_state_t;
endpackage

// ### verification/cpu_irq_model.sv
// Model of the CPU and interrupt controller facing the sleep manager.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module cpu_irq_model (
  // Clock
  input wire logic sys_clk,
  // Halt strobe and wake requests: any, address match, port, resume, counter
  output logic haltOpcode,
  output logic [4:0] wakeSrc
);
  // Quiet at time zero
  initial begin
    haltOpcode = 1'b0;
    wakeSrc = 5'h00;
  end
  // One-cycle strobe as the CPU executes the halt opcode
  task automatic halt();
    haltOpcode <= 1'b1;
    @(posedge sys_clk);
    haltOpcode <= 1'b0;
  endtask
  // A request stays up until the bench clears it
  task automatic set_src(input int s, input logic v);
    wakeSrc[s] <= v;
  endtask
endmodule

// ### verification/sleep_power_manager_sva.sv
// Checker for the sleep manager: clock enable relations seen at the top ports.
// Assumes a bind to sleep_power_manager, one clock and an active-low reset.
`timescale 1ns/1ps
module sleep_power_manager_chk
  import sleep_power_manager_pkg::*;
#(
  parameter int GATE_W = 8,
  parameter logic [GATE_W-1:0] PRESENT_MASK = 8'hFF,
  parameter int OSC_STARTUP_NS = 1000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Sleep sequencing
  input wire logic cpuStall,
  input wire logic cpuClkEn,
  input wire logic peripheralClkEn,
  input wire logic rtcClkEn,
  input wire logic sysOscEn,
  input wire logic rtcOscEn,
  // Pins, analog and always-on blocks
  input wire logic inputBufEn,
  input wire logic cmpEn,
  input wire logic brownoutThresholdFuses,
  input wire logic brownoutEn,
  input wire logic watchdogEnabled,
  input wire logic watchdogRun
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Steps of wake and deep sleep
  sequence s_oscWait; !cpuClkEn [*8]; endsequence
  sequence s_deepTwice; !peripheralClkEn ##1 !peripheralClkEn; endsequence
  // Wake stall and sleep entry
  property p_stallFour;
    $fell(cpuStall) |-> $past(cpuClkEn, 4) && !$past(cpuClkEn, 5);
  endproperty
  a_stallFour: assert property (p_stallFour) else $error("wake stall too short");
  property p_sleepStalls; !cpuClkEn |-> cpuStall; endproperty
  a_sleepStalls: assert property (p_sleepStalls) else $error("cpu clock off unstalled");
  property p_oscWait; $rose(sysOscEn) |-> s_oscWait; endproperty
  a_oscWait: assert property (p_oscWait) else $error("oscillator startup skipped");
  // Clock domain patterns per mode
  property p_idleKeeps; !cpuClkEn && peripheralClkEn |-> rtcClkEn && sysOscEn && rtcOscEn;
  endproperty
  a_idleKeeps: assert property (p_idleKeeps) else $error("idle stopped a clock");
  property p_allOff; !sysOscEn && !rtcOscEn |-> !rtcClkEn && !peripheralClkEn && !cpuClkEn;
  endproperty
  a_allOff: assert property (p_allOff) else $error("clock running with sources off");
  property p_rtcSrc; rtcClkEn |-> rtcOscEn; endproperty
  a_rtcSrc: assert property (p_rtcSrc) else $error("counter clock without source");
  // Deep sleep side effects
  property p_bufOff; s_deepTwice |-> !inputBufEn; endproperty
  a_bufOff: assert property (p_bufOff) else $error("input buffers on in deep sleep");
  property p_cmpOff; s_deepTwice |-> !cmpEn; endproperty
  a_cmpOff: assert property (p_cmpOff) else $error("comparator on in deep sleep");
  // Always-on blocks follow their enables
  property p_wdog; watchdogEnabled ##1 watchdogEnabled |-> watchdogRun; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog stopped");
  property p_bod; brownoutThresholdFuses ##1 brownoutThresholdFuses |-> brownoutEn; endproperty
  a_bod: assert property (p_bod) else $error("brownout detector stopped");
endmodule

bind sleep_power_manager sleep_power_manager_chk #(
  .GATE_W(GATE_W), .PRESENT_MASK(PRESENT_MASK), .OSC_STARTUP_NS(OSC_STARTUP_NS)
) chk_u (
  .sys_clk(sys_clk), .nrst(nrst), .cpuStall(cpuStall), .cpuClkEn(cpuClkEn),
  .peripheralClkEn(peripheralClkEn), .rtcClkEn(rtcClkEn), .sysOscEn(sysOscEn),
  .rtcOscEn(rtcOscEn), .inputBufEn(inputBufEn), .cmpEn(cmpEn),
  .brownoutThresholdFuses(brownoutThresholdFuses), .brownoutEn(brownoutEn),
  .watchdogEnabled(watchdogEnabled), .watchdogRun(watchdogRun)
);

// ### verification/tb.sv
// Self-checking bench for the sleep manager: registers, gating, modes, wake, reset.
// Assumes the design, the partner model and the checker compile before it.
`timescale 1ns/1ps
`include "sleep_power_manager_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
  import sleep_power_manager_pkg::*;
  localparam int OSCC = 10;
  localparam logic [7:0] PMASK = 8'h7F;
  // Bench signals
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic rtcEnabled = 1'b1, brownoutThresholdFuses = 1'b0, watchdogEnabled = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, haltOpcode;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic cpuStall, cpuClkEn, peripheralClkEn, rtcClkEn, sysOscEn, rtcOscEn, inputBufEn;
  logic adcEn, adcExtendedConv, cmpEn, vrefEn, brownoutEn, watchdogRun;
  logic nvmStop, brownoutSampled;
  logic [7:0] periphClkEn;
  logic [4:0] wakeSrc;
  integer seed = 24;
  int n_mismatch = 0;
  int checked = 0;
  // Clock
  always #5 sys_clk = ~sys_clk;
  // Design and partner
  sleep_power_manager #(.GATE_W(8), .PRESENT_MASK(PMASK), .OSC_STARTUP_NS(OSCC * 10)) dut_u (
    .*, .s_axi_wstrb(4'hF), .anyIrq(wakeSrc[0]), .twoWireAddrMatch(wakeSrc[1]),
    .asyncPortIrq(wakeSrc[2]), .usbResume(wakeSrc[3]), .rtcIrq(wakeSrc[4]));
  cpu_irq_model partner_u (.sys_clk(sys_clk), .haltOpcode(haltOpcode), .wakeSrc(wakeSrc));
  // Enables {cpu, peripheral, counter, system osc, counter osc} per mode
  function automatic logic [4:0] exp_en(input logic [2:0] m);
    case (m)
      MODE_ALL_CLOCKS_OFF: return 5'h00;
      MODE_COUNTER_KEPT: return 5'h05;
      MODE_OSCILLATORS_KEPT: return 5'h02;
      MODE_OSCILLATORS_AND_COUNTER_KEPT: return 5'h07;
      default: return 5'h0F;
    endcase
  endfunction
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait ran out
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // AXI4-Lite write: address and data together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    limit(n, 50);
  endtask
  // AXI4-Lite read: data and response taken at the rvalid edge
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    limit(n, 50);
  endtask
  // Main sequence
  initial begin
    logic [31:0] d, rv;
    logic [1:0] r;
    logic [4:0] ex;
    logic [7:0] g;
    int s, n, cnt, stl;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`SPM_OFS_SLEEP_CONTROL, rv, r);
    `CHK("ctrlRst", 32'h0, rv);
    rd(4'h2, rv, r);
    `CHK("misaligned", 2'h2, r);
    wr(`SPM_OFS_SLEEP_CONTROL, 32'hF4);
    rd(`SPM_OFS_SLEEP_CONTROL, rv, r);
    `CHK("ctrlUpper", 32'h4, rv);
    partner_u.halt();
    repeat (4) @(posedge sys_clk);
    `CHK("disarmed", 2'h2, {cpuClkEn, cpuStall});
    $display("test registers done");
    wr(`SPM_OFS_ANALOG_CTRL, 32'h7);
    wr(`SPM_OFS_ANALOG_CTRL, 32'h0);
    repeat (6) begin
      g = $random(seed);
      wr(`SPM_OFS_CLOCK_GATE, {24'h0, g});
      rd(`SPM_OFS_CLOCK_GATE, rv, r);
      `CHK("gateReg", {24'h0, g}, rv);
      `CHK("gateClk", ~g | ~PMASK, periphClkEn);
    end
    wr(`SPM_OFS_CLOCK_GATE, 32'h0);
    @(posedge sys_clk);
    `CHK("ungated", PMASK, periphClkEn & PMASK);
    wr(`SPM_OFS_ANALOG_CTRL, 32'hF);
    `CHK("extConv", 1'b1, adcExtendedConv);
    repeat (2) @(posedge sys_clk);
    $display("test gating done");
    for (int m = 0; m < 8; m++) begin
      d = $random(seed);
      watchdogEnabled <= d[0];
      brownoutThresholdFuses <= d[1];
      rtcEnabled <= d[4];
      wr(`SPM_OFS_SLEEP_CONTROL, {28'h0, m[2:0], 1'b1});
      partner_u.halt();
      repeat (4) @(posedge sys_clk);
      ex = exp_en(m[2:0]);
      // Outside idle, counter clock and its source only kept when the counter is enabled
      if (!d[4] && !ex[3]) ex = ex & 5'h1A;
      `CHK("clkEn", ex, {cpuClkEn, peripheralClkEn, rtcClkEn, sysOscEn, rtcOscEn});
      `CHK("inBuf", ex[3], inputBufEn);
      `CHK("cmp", ex[3], cmpEn);
      `CHK("vref", 1'b1, vrefEn);
      `CHK("adc", 1'b1, adcEn);
      `CHK("wdog", d[0], watchdogRun);
      `CHK("bod", d[1], brownoutEn);
      `CHK("bodSampled", !ex[3], brownoutSampled);
      `CHK("nvm", 1'b1, nvmStop);
      s = ex[3] ? 0 : ex[2] ? 4 : 1 + int'(d[3:2]) % 3;
      if (!ex[3]) begin
        partner_u.set_src(0, 1'b1);
        repeat (20) @(posedge sys_clk);
        `CHK("noWake", 1'b0, cpuClkEn);
        partner_u.set_src(0, 1'b0);
        @(posedge sys_clk);
      end
      partner_u.set_src(s, 1'b1);
      cnt = 0;
      stl = 0;
      n = 0;
      while (cpuStall !== 1'b0 && n < 400) begin
        @(posedge sys_clk);
        n++;
        cnt += (cpuClkEn === 1'b0);
        stl += (cpuClkEn === 1'b1 && cpuStall === 1'b1);
      end
      limit(n, 400);
      partner_u.set_src(s, 1'b0);
      if (!ex[1]) `CHK("oscWait", 1'b1, cnt >= OSCC);
      `CHK("awake", 2'h3, {cpuClkEn, peripheralClkEn});
      `CHK("stall", 4, stl);
      $display("test mode %0d done", m);
    end
    wr(`SPM_OFS_SLEEP_CONTROL, 32'h5);
    partner_u.halt();
    repeat (4) @(posedge sys_clk);
    `CHK("asleep", 1'b0, cpuClkEn);
    rd(`SPM_OFS_STATUS, rv, r);
    `CHK("status", 32'h85, rv);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    `CHK("resetWake", 2'h2, {cpuClkEn, cpuStall});
    rd(`SPM_OFS_SLEEP_CONTROL, rv, r);
    `CHK("ctrlAfter", 32'h0, rv);
    $display("test reset in sleep done");
    tally_and_finish();
  end
endmodule
